//--- include/rldrm_pkg.sv
// Shared constants for the log DMA / read multiple command block.
// Assumes one clock shared by both ends of the taskfile link.
package rldrm_pkg;
   // ==========================================
   // Opcodes
   localparam logic [7:0] OP_LOG_DMA = 8'h47;
   localparam logic [7:0] OP_RD_MULT = 8'hc4;

   // ==========================================
   // Taskfile register addresses
   localparam logic [3:0] TF_DATA = 4'h0;
   localparam logic [3:0] TF_ERR = 4'h1;
   localparam logic [3:0] TF_CNT = 4'h2;
   localparam logic [3:0] TF_LOW = 4'h3;
   localparam logic [3:0] TF_MID = 4'h4;
   localparam logic [3:0] TF_HIGH = 4'h5;
   localparam logic [3:0] TF_DEV = 4'h6;
   localparam logic [3:0] TF_CMD = 4'h7;
   localparam logic [3:0] TF_CTL = 4'h8;

   // ==========================================
   // Field positions
   localparam int ST_BSY = 7;
   localparam int ST_RDY = 6;
   localparam int ST_DF = 5;
   localparam int ST_DSC = 4;
   localparam int ST_DRQ = 3;
   localparam int ST_ERR = 0;
   localparam int ER_UNC = 6;
   localparam int ER_IDN = 4;
   localparam int ER_ABT = 2;
   localparam int CTL_HOB = 7;
   localparam int DEV_LBA = 6;
   localparam int C_START = 0;
   localparam int C_DMA = 1;

   // ==========================================
   // Sizes and reset values
   localparam int SECTOR_WORD_BITS = 8;
   localparam logic [8:0] MULT_FULL_SECTORS = 9'h100;
   localparam logic [7:0] DEVHD_BASE = 8'he0;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;

   // ==========================================
   // Controller APB offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_COUNT = 8'h08;
   localparam logic [7:0] A_ADDR = 8'h0c;
   localparam logic [7:0] A_DATA = 8'h10;

   // ==========================================
   // States
   typedef enum logic [1:0] {
      D_IDLE = 2'b01,
      D_XFER = 2'b10
   } rldrm_dev_st_e;

   typedef enum logic [6:0] {
      H_IDLE = 7'b0000001,
      H_WRITE = 7'b0000010,
      H_WAIT = 7'b0000100,
      H_POLL = 7'b0001000,
      H_READ = 7'b0010000,
      H_HOLD = 7'b0100000,
      H_FIN = 7'b1000000
   } rldrm_host_st_e;
endpackage

//--- include/rldrm_if.sv
// Taskfile link between the controller and the drive command logic.
// Both ends run on the same pclk; no crossing is needed.
`timescale 1ns/1ps
interface rldrm_if (
   input wire logic pclk,
   input wire logic presetn
);
   logic tf_req;
   logic tf_we;
   logic [3:0] tf_addr;
   logic [15:0] tf_wdata;
   logic tf_ack;
   logic [15:0] tf_rdata;
   logic intrq;
   logic dma_valid;
   logic [15:0] dma_data;
   logic dma_ready;

   modport dev (
      input pclk, presetn, tf_req, tf_we, tf_addr, tf_wdata, dma_ready,
      output tf_ack, tf_rdata, intrq, dma_valid, dma_data
   );
   modport host (
      input pclk, presetn, tf_ack, tf_rdata, intrq, dma_valid, dma_data,
      output tf_req, tf_we, tf_addr, tf_wdata, dma_ready
   );
endinterface

//--- logic/rldrm_dev.sv
// Drive-side command logic: log read by DMA and block-multiple PIO read.
// Assumes the media/log source answers word by word on src_* with back-pressure.
`timescale 1ns/1ps
module rldrm_dev (
   // Taskfile link
   rldrm_if.dev bus,
   // Block size from the earlier multiple-count setting
   input wire logic [7:0] mult_cnt,
   // Data source request
   output logic src_req,
   output logic src_log,
   output logic [47:0] src_addr,
   output logic [16:0] src_sectors,
   // Data source words
   input wire logic src_valid,
   input wire logic [15:0] src_data,
   output logic src_ready,
   // Data source failures
   input wire logic src_unc,
   input wire logic src_idnf
);
   // ==========================================
   // State
   typedef struct packed {
      rldrm_pkg::rldrm_dev_st_e st;
      logic [3:0][7:0] cur;
      logic [3:0][7:0] prv;
      logic [7:0] devhd;
      logic high_byte_select;
      logic [7:0] err;
      logic df;
      logic intrq;
      logic is_dma;
      logic [15:0] word;
      logic word_v;
      logic [24:0] tot;
      logic [15:0] blk;
      logic first;
      logic [15:0] rdata;
      logic ack;
      logic req;
      logic log_sel;
      logic [47:0] addr;
      logic [16:0] sec;
   } rldrm_dev_s;

   localparam rldrm_dev_s DEV_RESET = '{st: rldrm_pkg::D_IDLE, default: '0};

   rldrm_dev_s s_q;
   rldrm_dev_s s_d;
   logic drq;
   logic busy_flag;
   logic [7:0] stat;
   logic consume;
   logic src_fire;
   logic cmd_wr;
   logic [1:0] idx;
   logic [15:0] cnt16;
   logic [8:0] msec;
   logic [15:0] blk_words;

   // ==========================================
   // Handshakes
   assign drq = (s_q.st == rldrm_pkg::D_XFER) && s_q.word_v && !s_q.is_dma;
   assign busy_flag = (s_q.st != rldrm_pkg::D_IDLE) && !drq;
   assign bus.dma_valid = (s_q.st == rldrm_pkg::D_XFER) && s_q.word_v && s_q.is_dma;
   assign src_ready = (s_q.st == rldrm_pkg::D_XFER) && !s_q.word_v;
   assign src_fire = src_valid && src_ready;
   assign idx = 2'(bus.tf_addr - rldrm_pkg::TF_CNT);
   assign blk_words = {mult_cnt, 8'h00};

   // ==========================================
   // Outputs
   assign bus.tf_ack = s_q.ack;
   assign bus.tf_rdata = s_q.rdata;
   assign bus.intrq = s_q.intrq;
   assign bus.dma_data = s_q.word;
   assign src_req = s_q.req;
   assign src_log = s_q.log_sel;
   assign src_addr = s_q.addr;
   assign src_sectors = s_q.sec;

   always_comb begin
      stat = rldrm_pkg::RST_BYTE;
      stat[rldrm_pkg::ST_BSY] = busy_flag;
      stat[rldrm_pkg::ST_RDY] = 1'b1;
      stat[rldrm_pkg::ST_DF] = s_q.df;
      stat[rldrm_pkg::ST_DSC] = 1'b1;
      stat[rldrm_pkg::ST_DRQ] = drq;
      stat[rldrm_pkg::ST_ERR] = (s_q.err != rldrm_pkg::RST_BYTE);
   end

   // ==========================================
   // Next state
   always_comb begin
      s_d = s_q;
      s_d.ack = 1'b0;
      s_d.req = 1'b0;
      cmd_wr = 1'b0;
      consume = bus.dma_valid && bus.dma_ready;
      cnt16 = {s_q.prv[0], s_q.cur[0]};
      msec = (s_q.cur[0] == rldrm_pkg::RST_BYTE) ? rldrm_pkg::MULT_FULL_SECTORS : {1'b0, s_q.cur[0]};
      // Register access, one answer per request
      if (bus.tf_req) begin
         s_d.ack = 1'b1;
         s_d.rdata = rldrm_pkg::RST_WORD;
         if (bus.tf_we) begin
            case (bus.tf_addr)
               rldrm_pkg::TF_CNT, rldrm_pkg::TF_LOW, rldrm_pkg::TF_MID, rldrm_pkg::TF_HIGH: begin
                  s_d.prv[idx] = s_q.cur[idx];
                  s_d.cur[idx] = bus.tf_wdata[7:0];
                  s_d.high_byte_select = 1'b0;
               end
               rldrm_pkg::TF_DEV: begin
                  s_d.devhd = bus.tf_wdata[7:0];
               end
               rldrm_pkg::TF_CTL: begin
                  s_d.high_byte_select = bus.tf_wdata[rldrm_pkg::CTL_HOB];
               end
               rldrm_pkg::TF_CMD: begin
                  // Commands written while busy are dropped
                  cmd_wr = (s_q.st == rldrm_pkg::D_IDLE);
               end
               default: begin
               end
            endcase
         end else begin
            case (bus.tf_addr)
               rldrm_pkg::TF_DATA: begin
                  if (drq) begin
                     s_d.rdata = s_q.word;
                     consume = 1'b1;
                  end
               end
               rldrm_pkg::TF_ERR: begin
                  s_d.rdata = {8'h00, s_q.err};
               end
               rldrm_pkg::TF_CNT, rldrm_pkg::TF_LOW, rldrm_pkg::TF_MID, rldrm_pkg::TF_HIGH: begin
                  // Contents after a command carry no meaning
                  s_d.rdata = {8'h00, s_q.high_byte_select ? s_q.prv[idx] : s_q.cur[idx]};
               end
               rldrm_pkg::TF_DEV: begin
                  s_d.rdata = {8'h00, s_q.devhd};
               end
               rldrm_pkg::TF_CMD: begin
                  s_d.rdata = {8'h00, stat};
                  s_d.intrq = 1'b0;
               end
               default: begin
               end
            endcase
         end
      end

      // Command decode
      if (cmd_wr) begin
         s_d.err = rldrm_pkg::RST_BYTE;
         s_d.df = 1'b0;
         s_d.first = 1'b1;
         s_d.blk = blk_words;
         if (bus.tf_wdata[7:0] == rldrm_pkg::OP_LOG_DMA) begin
            if (cnt16 == rldrm_pkg::RST_WORD) begin
               s_d.err[rldrm_pkg::ER_ABT] = 1'b1;
               s_d.intrq = 1'b1;
            end else begin
               s_d.st = rldrm_pkg::D_XFER;
               s_d.is_dma = 1'b1;
               s_d.req = 1'b1;
               s_d.log_sel = 1'b1;
               s_d.tot = {1'b0, cnt16, 8'h00};
               s_d.sec = {1'b0, cnt16};
               s_d.addr = {24'h000000, s_q.prv[2], s_q.cur[2], s_q.cur[1]};
            end
         end else if (bus.tf_wdata[7:0] == rldrm_pkg::OP_RD_MULT) begin
            if (mult_cnt == rldrm_pkg::RST_BYTE || !s_q.devhd[rldrm_pkg::DEV_LBA]) begin
               s_d.err[rldrm_pkg::ER_ABT] = 1'b1;
               s_d.intrq = 1'b1;
            end else begin
               s_d.st = rldrm_pkg::D_XFER;
               s_d.is_dma = 1'b0;
               s_d.req = 1'b1;
               s_d.log_sel = 1'b0;
               s_d.tot = {8'h00, msec, 8'h00};
               s_d.sec = {8'h00, msec};
               s_d.addr = {20'h00000, s_q.devhd[3:0], s_q.cur[3], s_q.cur[2], s_q.cur[1]};
            end
         end else begin
            s_d.err[rldrm_pkg::ER_ABT] = 1'b1;
            s_d.intrq = 1'b1;
         end
      end

      // Word drained by host
      if (consume) begin
         s_d.word_v = 1'b0;
         s_d.tot = s_q.tot - 25'd1;
         s_d.blk = s_q.blk - 16'd1;
         if (s_q.blk == 16'd1) begin
            s_d.first = 1'b1;
            s_d.blk = blk_words;
         end
         if (s_q.tot == 25'd1) begin
            s_d.st = rldrm_pkg::D_IDLE;
            s_d.df = 1'b0;
            if (s_q.is_dma) begin
               s_d.intrq = 1'b1;
            end
         end
      end

      // Word arriving from media or log store
      if (src_fire) begin
         s_d.word = src_data;
         s_d.word_v = 1'b1;
         if (s_q.first && !s_q.is_dma) begin
            s_d.intrq = 1'b1;
            s_d.first = 1'b0;
         end
      end

      // Source failure ends the command with an error
      if ((s_q.st == rldrm_pkg::D_XFER) && (src_unc || src_idnf)) begin
         s_d.st = rldrm_pkg::D_IDLE;
         s_d.word_v = 1'b0;
         s_d.df = 1'b0;
         s_d.err[rldrm_pkg::ER_UNC] = src_unc;
         s_d.err[rldrm_pkg::ER_IDN] = src_idnf;
         s_d.intrq = 1'b1;
      end
   end

   // ==========================================
   // Registers
   always_ff @(posedge bus.pclk or negedge bus.presetn) begin
      if (!bus.presetn) begin
         s_q <= DEV_RESET;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

//--- logic/rldrm_host.sv
// Controller end: takes orders over APB and drives the taskfile link.
// Assumes the drive answers each taskfile request one cycle later.
`timescale 1ns/1ps
module rldrm_host (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Taskfile link
   rldrm_if.host bus
);
   // ==========================================
   // State
   typedef struct packed {
      rldrm_pkg::rldrm_host_st_e st;
      logic [2:0] idx;
      logic go_dma;
      logic [15:0] cnt;
      logic [31:0] addr;
      logic [7:0] dstat;
      logic [7:0] derr;
      logic done;
      logic [15:0] buf_w;
      logic buf_v;
      logic pend;
      logic req;
      logic we;
      logic [3:0] a;
      logic [15:0] wd;
      logic [31:0] prdata;
   } rldrm_host_s;

   localparam rldrm_host_s HOST_RESET = '{st: rldrm_pkg::H_IDLE, default: '0};

   rldrm_host_s s_q;
   rldrm_host_s s_d;
   logic busy;
   logic [11:0] step;

   assign busy = (s_q.st != rldrm_pkg::H_IDLE);
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign prdata = s_q.prdata;
   assign bus.tf_req = s_q.req;
   assign bus.tf_we = s_q.we;
   assign bus.tf_addr = s_q.a;
   assign bus.tf_wdata = s_q.wd;
   assign bus.dma_ready = s_q.go_dma && !s_q.buf_v && (s_q.st == rldrm_pkg::H_WAIT);

   // Taskfile write sequence: {address, byte}
   always_comb begin
      case (s_q.idx)
         3'd0: step = {rldrm_pkg::TF_CNT, s_q.cnt[15:8]};
         3'd1: step = {rldrm_pkg::TF_CNT, s_q.cnt[7:0]};
         3'd2: step = {rldrm_pkg::TF_LOW, s_q.addr[7:0]};
         3'd3: step = {rldrm_pkg::TF_MID, s_q.addr[23:16]};
         3'd4: step = {rldrm_pkg::TF_MID, s_q.addr[15:8]};
         3'd5: step = {rldrm_pkg::TF_HIGH, s_q.addr[23:16]};
         3'd6: step = {rldrm_pkg::TF_DEV, rldrm_pkg::DEVHD_BASE | {4'h0, s_q.addr[27:24]}};
         default: step = {rldrm_pkg::TF_CMD, s_q.go_dma ? rldrm_pkg::OP_LOG_DMA : rldrm_pkg::OP_RD_MULT};
      endcase
   end

   // ==========================================
   // Next state
   always_comb begin
      s_d = s_q;
      s_d.req = 1'b0;
      if (psel && !penable) begin
         case (paddr)
            rldrm_pkg::A_CTRL: s_d.prdata = {30'h0, s_q.go_dma, busy};
            rldrm_pkg::A_STAT: s_d.prdata = {14'h0, busy, s_q.done, s_q.derr, s_q.dstat};
            rldrm_pkg::A_COUNT: s_d.prdata = {16'h0000, s_q.cnt};
            rldrm_pkg::A_ADDR: s_d.prdata = s_q.addr;
            rldrm_pkg::A_DATA: s_d.prdata = {15'h0, s_q.buf_v, s_q.buf_w};
            default: s_d.prdata = 32'h00000000;
         endcase
      end
      if (psel && penable && pwrite && !busy) begin
         case (paddr)
            rldrm_pkg::A_CTRL: begin
               if (pwdata[rldrm_pkg::C_START]) begin
                  s_d.go_dma = pwdata[rldrm_pkg::C_DMA];
                  s_d.done = 1'b0;
                  s_d.idx = 3'd0;
                  s_d.st = rldrm_pkg::H_WRITE;
               end
            end
            rldrm_pkg::A_COUNT: s_d.cnt = pwdata[15:0];
            rldrm_pkg::A_ADDR: s_d.addr = pwdata;
            default: begin
            end
         endcase
      end
      // Pop only a word that setup reported; one landing at setup must survive
      if (psel && penable && !pwrite && paddr == rldrm_pkg::A_DATA && s_q.prdata[16]) begin
         s_d.buf_v = 1'b0;
      end
      if (bus.dma_valid && bus.dma_ready) begin
         s_d.buf_w = bus.dma_data;
         s_d.buf_v = 1'b1;
      end
      // Issue one taskfile access at a time
      if (!s_q.pend && (s_q.st == rldrm_pkg::H_WRITE || s_q.st == rldrm_pkg::H_POLL ||
          s_q.st == rldrm_pkg::H_READ || s_q.st == rldrm_pkg::H_FIN)) begin
         s_d.req = 1'b1;
         s_d.pend = 1'b1;
         s_d.we = (s_q.st == rldrm_pkg::H_WRITE);
         s_d.wd = {8'h00, step[7:0]};
         case (s_q.st)
            rldrm_pkg::H_WRITE: s_d.a = step[11:8];
            rldrm_pkg::H_POLL: s_d.a = rldrm_pkg::TF_CMD;
            rldrm_pkg::H_READ: s_d.a = rldrm_pkg::TF_DATA;
            default: s_d.a = rldrm_pkg::TF_ERR;
         endcase
      end
      case (s_q.st)
         rldrm_pkg::H_WRITE: begin
            if (bus.tf_ack) begin
               s_d.pend = 1'b0;
               s_d.idx = s_q.idx + 3'd1;
               if (s_q.idx == 3'd7) begin
                  s_d.st = rldrm_pkg::H_WAIT;
               end
            end
         end
         rldrm_pkg::H_WAIT: begin
            if (bus.intrq) begin
               s_d.st = rldrm_pkg::H_POLL;
            end
         end
         rldrm_pkg::H_POLL: begin
            if (bus.tf_ack) begin
               s_d.pend = 1'b0;
               s_d.dstat = bus.tf_rdata[7:0];
               if (bus.tf_rdata[rldrm_pkg::ST_BSY]) begin
                  s_d.st = s_q.go_dma ? rldrm_pkg::H_WAIT : rldrm_pkg::H_POLL;
               end else if (bus.tf_rdata[rldrm_pkg::ST_DRQ]) begin
                  s_d.st = rldrm_pkg::H_READ;
               end else begin
                  s_d.st = rldrm_pkg::H_FIN;
               end
            end
         end
         rldrm_pkg::H_READ: begin
            if (bus.tf_ack) begin
               s_d.pend = 1'b0;
               s_d.buf_w = bus.tf_rdata;
               s_d.buf_v = 1'b1;
               s_d.st = rldrm_pkg::H_HOLD;
            end
         end
         rldrm_pkg::H_HOLD: begin
            if (!s_q.buf_v) begin
               s_d.st = rldrm_pkg::H_POLL;
            end
         end
         rldrm_pkg::H_FIN: begin
            if (bus.tf_ack) begin
               s_d.pend = 1'b0;
               s_d.derr = bus.tf_rdata[7:0];
               s_d.done = 1'b1;
               s_d.st = rldrm_pkg::H_IDLE;
            end
         end
         default: begin
         end
      endcase
   end

   // ==========================================
   // Registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= HOST_RESET;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

//--- testbench/rldrm_props.sv
// Checker for the taskfile link between controller and drive logic.
// Assumes one clock; watches the interface signals only.
`timescale 1ns/1ps
module rldrm_props (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Controller side
   input wire logic tf_req,
   input wire logic tf_we,
   input wire logic [3:0] tf_addr,
   input wire logic [15:0] tf_wdata,
   input wire logic dma_ready,
   // Drive side
   input wire logic tf_ack,
   input wire logic [15:0] tf_rdata,
   input wire logic intrq,
   input wire logic dma_valid,
   input wire logic [15:0] dma_data
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic rd_stat_q;
   logic rd_err_q;
   logic wr_q;
   // ==========================================
   // Kind of the request now being answered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_stat_q <= 1'b0;
         rd_err_q <= 1'b0;
         wr_q <= 1'b0;
      end else begin
         rd_stat_q <= tf_req && !tf_we && tf_addr == rldrm_pkg::TF_CMD;
         rd_err_q <= tf_req && !tf_we && tf_addr == rldrm_pkg::TF_ERR;
         wr_q <= tf_req && tf_we;
      end
   end
   // ==========================================
   // Properties
   property p_ack_next;
      tf_req |=> tf_ack ##1 !tf_ack;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after request");
   property p_ack_cause;
      tf_ack |-> $past(tf_req);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_req_gap;
      tf_req |=> !tf_req;
   endproperty
   a_req_gap: assert property (p_req_gap) else $error("request issued before ack");
   property p_stat_fixed;
      tf_ack && rd_stat_q |-> tf_rdata[rldrm_pkg::ST_RDY] && tf_rdata[rldrm_pkg::ST_DSC] && !tf_rdata[rldrm_pkg::ST_DF];
   endproperty
   a_stat_fixed: assert property (p_stat_fixed) else $error("status ready or fault bits wrong");
   property p_bsy_drq;
      tf_ack && rd_stat_q |-> !(tf_rdata[rldrm_pkg::ST_BSY] && tf_rdata[rldrm_pkg::ST_DRQ]);
   endproperty
   a_bsy_drq: assert property (p_bsy_drq) else $error("busy and data request together");
   property p_err_zero;
      tf_ack && rd_err_q |-> (tf_rdata[7:0] & 8'hab) == 8'h00;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("unused error bits set");
   property p_wr_zero;
      tf_ack && wr_q |-> tf_rdata == 16'h0000;
   endproperty
   a_wr_zero: assert property (p_wr_zero) else $error("read data on a write");
   property p_dma_hold;
      // A media fault may drop the held word; the interrupt marks that end
      dma_valid && !dma_ready |=> intrq || (dma_valid && $stable(dma_data));
   endproperty
   a_dma_hold: assert property (p_dma_hold) else $error("dma word dropped while stalled");
   property p_intrq_fall;
      $fell(intrq) |-> rd_stat_q || $past(rd_stat_q);
   endproperty
   a_intrq_fall: assert property (p_intrq_fall) else $error("interrupt cleared without status read");
endmodule

//--- testbench/test_read_log_dma_and_read_multiple.sv
// Bench: APB orders into the controller, a word source behind the drive.
// Assumes done is cleared by each new start.
`timescale 1ns/1ps
module test_read_log_dma_and_read_multiple;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr;
   logic [7:0] mult_cnt = 8'h00;
   logic src_req, src_log, src_ready;
   logic [47:0] src_addr, cap_addr;
   logic [16:0] src_sectors, cap_sec;
   logic src_valid = 1'b0, src_unc = 1'b0, src_idnf = 1'b0, src_on = 1'b0, cap_log, irq_prev = 1'b0;
   logic [15:0] src_data = 16'h0000, data_base;
   logic [31:0] lfsr = 32'h9906;
   int sidx = 0, fault_at, fault_kind = 0, req_cnt = 0, irq_cnt = 0, fail_count = 0, checks = 0;
   rldrm_if bus (.pclk(pclk), .presetn(presetn));
   rldrm_dev rldrm_dev_inst (.bus(bus), .mult_cnt(mult_cnt), .src_req(src_req), .src_log(src_log),
      .src_addr(src_addr), .src_sectors(src_sectors), .src_valid(src_valid), .src_data(src_data),
      .src_ready(src_ready), .src_unc(src_unc), .src_idnf(src_idnf));
   rldrm_host rldrm_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus));
   rldrm_props props_inst (.pclk(pclk), .presetn(presetn), .tf_req(bus.tf_req), .tf_we(bus.tf_we),
      .tf_addr(bus.tf_addr), .tf_wdata(bus.tf_wdata), .dma_ready(bus.dma_ready), .tf_ack(bus.tf_ack),
      .tf_rdata(bus.tf_rdata), .intrq(bus.intrq), .dma_valid(bus.dma_valid), .dma_data(bus.dma_data));
   initial begin
      forever #5 pclk = ~pclk;
   end
   // ==========================================
   // Helpers
   function automatic logic [31:0] lfsr_f(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [15:0] exp_word(input int n);
      return data_base ^ (n[15:0] * 16'h0107);
   endfunction
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      chk("pslverr", 32'h0, {31'h0, pslverr});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // ==========================================
   // Word source; stops after the requested sectors or at a fault
   always @(posedge pclk) begin : source
      int n;
      src_unc <= 1'b0;
      src_idnf <= 1'b0;
      if (bus.intrq === 1'b1 && !irq_prev) irq_cnt <= irq_cnt + 1;
      irq_prev <= bus.intrq;
      n = sidx + ((src_valid && src_ready === 1'b1) ? 1 : 0);
      if (src_req === 1'b1) begin
         req_cnt <= req_cnt + 1;
         cap_log <= src_log;
         cap_addr <= src_addr;
         cap_sec <= src_sectors;
         sidx <= 0;
         src_on <= 1'b1;
         src_valid <= 1'b0;
      end else if (src_on) begin
         sidx <= n;
         if (fault_kind != 0 && n == fault_at) begin
            src_unc <= fault_kind == 1;
            src_idnf <= fault_kind == 2;
            src_on <= 1'b0;
            src_valid <= 1'b0;
         end else if (n == cap_sec * 256) begin
            src_on <= 1'b0;
            src_valid <= 1'b0;
         end else begin
            src_valid <= 1'b1;
            src_data <= exp_word(n);
         end
      end else begin
         // Released lines must not look like the last word
         src_data <= ~src_data;
      end
   end
   // ==========================================
   // One command from start to done
   task automatic run(input logic dma, input logic [15:0] cnt, input logic [7:0] mc, input int fk, input int fa,
      input logic [15:0] est, input int ewords, input int ereq, input int eirq);
      logic [31:0] rd, adr;
      int got, req0, irq0;
      lfsr = lfsr_f(lfsr);
      adr = dma ? (lfsr & 32'h00ffffff) : (lfsr & 32'h0fffffff);
      lfsr = lfsr_f(lfsr);
      data_base = lfsr[15:0];
      fault_kind = fk;
      fault_at = fa;
      req0 = req_cnt;
      irq0 = irq_cnt;
      got = 0;
      mult_cnt <= mc;
      apb(1'b1, rldrm_pkg::A_COUNT, {16'h0000, cnt}, rd);
      apb(1'b1, rldrm_pkg::A_ADDR, adr, rd);
      apb(1'b0, rldrm_pkg::A_COUNT, 32'h0, rd);
      chk("count register", {16'h0000, cnt}, rd);
      apb(1'b0, rldrm_pkg::A_ADDR, 32'h0, rd);
      chk("address register", adr, rd);
      apb(1'b1, rldrm_pkg::A_CTRL, {30'h0, dma, 1'b1}, rd);
      for (int k = 0; k < 3000; k++) begin
         apb(1'b0, rldrm_pkg::A_DATA, 32'h0, rd);
         if (rd[16] === 1'b1) begin
            chk("data word", {16'h0, exp_word(got)}, {16'h0, rd[15:0]});
            got++;
         end
         apb(1'b0, rldrm_pkg::A_STAT, 32'h0, rd);
         if (rd[16] === 1'b1) break;
      end
      chk("done", 32'h1, {31'h0, rd[16]});
      chk("error and status", {16'h0, est}, {16'h0, rd[15:0]});
      if (ewords >= 0) chk("word count", ewords, got);
      chk("source requests", ereq, req_cnt - req0);
      if (eirq >= 0) chk("interrupts", eirq, irq_cnt - irq0);
      if (ereq > 0) begin
         chk("source log flag", {31'h0, dma}, {31'h0, cap_log});
         chk("source address", adr, cap_addr[31:0]);
         chk("source sectors", {16'h0, cnt}, {15'h0, cap_sec});
      end
   endtask
   initial begin : main
      logic [7:0] mc;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      run(1'b1, 16'h0001, 8'h00, 0, 0, 16'h0050, 256, 1, 1);
      run(1'b1, 16'h0000, 8'h01, 0, 0, 16'h0451, 0, 0, 1);
      for (int i = 0; i < 2; i++) begin
         lfsr = lfsr_f(lfsr);
         mc = (i == 0) ? 8'h01 : 8'h02;
         run(1'b0, 16'h0002, mc, 0, 0, 16'h0050, 512, 1, 2 / mc);
      end
      run(1'b0, 16'h0001, 8'h00, 0, 0, 16'h0451, 0, 0, 1);
      run(1'b0, 16'h0001, 8'h01, 1, 100, 16'h4051, -1, 1, -1);
      run(1'b1, 16'h0001, 8'h00, 2, 7, 16'h1051, -1, 1, -1);
      end_of_test();
   end
   initial begin : watchdog
      repeat (60000) @(posedge pclk);
      fail_count++;
      $display("[ERR] watchdog expected done seen hang");
      end_of_test();
   end
endmodule
